// ---- pdpc_pll_dynamic_phase_config.sv ----
module pdpc_pll_dynamic_phase_config (
   // Clock, reset, enable
   input  wire logic                        core_clk,
   input  wire logic                        reset,
   input  wire logic                        clk_en,
   // Static configuration, caught once after reset
   input  wire pdpc_pkg::pdpc_static_cfg_s  static_cfg,
   // Phase-shift handshake
   input  wire logic                        shift_control_clock,
   input  wire pdpc_pkg::pdpc_shift_req_s   shift_req,
   output logic                             shift_complete,
   // Reconfiguration port
   input  wire logic                        reconfig_clock,
   input  wire pdpc_pkg::pdpc_reconfig_req_s reconfig_req,
   output logic [pdpc_pkg::DATA_W-1:0]      reconfig_read_data,
   // Loop state
   output logic                             pll_locked,
   output pdpc_pkg::pdpc_static_cfg_s       static_cfg_held,
   output logic [pdpc_pkg::NUM_OUTPUTS*pdpc_pkg::PHASE_W-1:0] out_phase
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Writable bits per location; unmapped bytes stay zero
   function automatic logic [pdpc_pkg::DATA_W-1:0] loc_mask(
      input logic [pdpc_pkg::IDX_W-1:0] idx
   );
      logic [pdpc_pkg::DATA_W-1:0] m;
      m = pdpc_pkg::MASK_NONE;
      if (idx >= pdpc_pkg::REFERENCE_DIVIDER && idx <= pdpc_pkg::OUT4_DIVIDER) begin
         m = pdpc_pkg::MASK_FIELD7;
      end else if (idx == pdpc_pkg::PHASE_LOW_OUTPUTS) begin
         m = pdpc_pkg::MASK_FULL;
      end else if (idx == pdpc_pkg::PHASE_HIGH_OUTPUTS) begin
         m = pdpc_pkg::MASK_FIELD7;
      end
      return m;
   endfunction : loc_mask

   // Divider locations hold a factor; these reset to divide by one
   function automatic logic is_divider(
      input logic [pdpc_pkg::IDX_W-1:0] idx
   );
      return (idx == pdpc_pkg::REFERENCE_DIVIDER) ||
             (idx == pdpc_pkg::FEEDBACK_DIVIDER) ||
             (idx >= pdpc_pkg::OUT0_DIVIDER && idx <= pdpc_pkg::OUT4_DIVIDER &&
              idx[0] == pdpc_pkg::OUT0_DIVIDER[0]);
   endfunction : is_divider

   // ****************************************************************
   // Storage and state
   // ****************************************************************
   logic [pdpc_pkg::DATA_W-1:0]     store_r [pdpc_pkg::STORE_DEPTH];
   logic                            rcfg_clk_prev_r;
   logic                            shift_clk_prev_r;
   logic                            cfg_caught_r;
   pdpc_pkg::pdpc_shift_state_e     shift_state_r;
   pdpc_pkg::pdpc_shift_state_e     shift_state_nxt;
   logic                            step_apply;
   logic [2:0]                      step_sel_r;
   logic                            step_up_r;
   logic [pdpc_pkg::LOCK_CNT_W-1:0] lock_cnt_r;
   logic                            rcfg_rise;
   logic                            shift_rise;
   logic                            rcfg_write;
   logic [pdpc_pkg::IDX_W-1:0]      rcfg_idx;
   logic                            rcfg_in_range;
   logic [pdpc_pkg::NUM_OUTPUTS*pdpc_pkg::PHASE_W-1:0] phase_flat;
   logic [pdpc_pkg::NUM_OUTPUTS*pdpc_pkg::PHASE_W-1:0] phase_new;
   logic [pdpc_pkg::PHASE_W-1:0]    phase_sel;

   // ****************************************************************
   // Port clock edge detection
   // ****************************************************************

   // Both port clocks are sampled as plain synchronous inputs
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rcfg_clk_prev_r  <= 1'b0;
         shift_clk_prev_r <= 1'b0;
      end else if (clk_en) begin
         rcfg_clk_prev_r  <= reconfig_clock;
         shift_clk_prev_r <= shift_control_clock;
      end
   end

   assign rcfg_rise  = reconfig_clock & ~rcfg_clk_prev_r;
   assign shift_rise = shift_control_clock & ~shift_clk_prev_r;

   // Address above the store reaches nothing
   assign rcfg_in_range = (reconfig_req.address < 6'(pdpc_pkg::STORE_DEPTH));
   assign rcfg_idx      = reconfig_req.address[pdpc_pkg::IDX_W-1:0];
   assign rcfg_write    = rcfg_rise & reconfig_req.select &
                          reconfig_req.write_enable & rcfg_in_range;

   // ****************************************************************
   // Static configuration
   // ****************************************************************

   // Caught once at the first enabled cycle after reset, then frozen
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cfg_caught_r    <= 1'b0;
         static_cfg_held <= '0;
      end else if (clk_en && !cfg_caught_r) begin
         cfg_caught_r    <= 1'b1;
         static_cfg_held <= static_cfg;
      end
   end

   // ****************************************************************
   // Phase shift handshake
   // ****************************************************************

   // Phase fields as packed across locations 0x12 and 0x13
   assign phase_flat = {store_r[pdpc_pkg::PHASE_HIGH_OUTPUTS][6:0],
                        store_r[pdpc_pkg::PHASE_LOW_OUTPUTS]};

   // Step the chosen output; a select above four changes nothing
   always_comb begin
      phase_new = phase_flat;
      phase_sel = '0;
      for (int i = 0; i < pdpc_pkg::NUM_OUTPUTS; i++) begin
         if (step_sel_r == 3'(i)) begin
            phase_sel = phase_flat[i*pdpc_pkg::PHASE_W +: pdpc_pkg::PHASE_W];
            // One 45 degree VCO unit, wraps modulo eight
            phase_new[i*pdpc_pkg::PHASE_W +: pdpc_pkg::PHASE_W] =
               step_up_r ? phase_sel + 3'h1 : phase_sel - 3'h1;
         end
      end
   end

   // Step counted after two high samples; the feedback mode never gates it
   always_comb begin
      shift_state_nxt = shift_state_r;
      step_apply      = 1'b0;
      case (shift_state_r)
         pdpc_pkg::PDPC_SH_IDLE: begin
            if (shift_rise && shift_req.step_pulse) begin
               shift_state_nxt = pdpc_pkg::PDPC_SH_COUNT;
            end
         end
         pdpc_pkg::PDPC_SH_COUNT: begin
            if (shift_rise) begin
               if (shift_req.step_pulse) begin
                  step_apply      = 1'b1;
                  shift_state_nxt = pdpc_pkg::PDPC_SH_DONE;
               end else begin
                  // Too short a pulse is dropped
                  shift_state_nxt = pdpc_pkg::PDPC_SH_IDLE;
               end
            end
         end
         pdpc_pkg::PDPC_SH_DONE: begin
            // One step per pulse: wait for it to fall
            if (shift_rise && !shift_req.step_pulse) begin
               shift_state_nxt = pdpc_pkg::PDPC_SH_IDLE;
            end
         end
         default: begin
            shift_state_nxt = pdpc_pkg::PDPC_SH_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         shift_state_r <= pdpc_pkg::PDPC_SH_IDLE;
      end else if (clk_en) begin
         shift_state_r <= shift_state_nxt;
      end
   end

   // Select and direction held from the first high sample
   always_ff @(posedge core_clk) begin
      if (reset) begin
         step_sel_r <= '0;
         step_up_r  <= 1'b0;
      end else if (clk_en && shift_state_r == pdpc_pkg::PDPC_SH_IDLE &&
                   shift_rise && shift_req.step_pulse) begin
         step_sel_r <= shift_req.output_select;
         step_up_r  <= shift_req.step_up;
      end
   end

   // Done falls when a step starts, rises when it lands
   always_ff @(posedge core_clk) begin
      if (reset) begin
         shift_complete <= 1'b1;
      end else if (clk_en) begin
         if (step_apply) begin
            shift_complete <= 1'b1;
         end else if (shift_state_r == pdpc_pkg::PDPC_SH_IDLE &&
                      shift_rise && shift_req.step_pulse) begin
            shift_complete <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Configuration store
   // ****************************************************************

   // One process per byte; a step wins over a same-cycle port write to 0x12 or 0x13
   generate
      for (genvar g = 0; g < pdpc_pkg::STORE_DEPTH; g++) begin : g_store
         localparam logic [pdpc_pkg::IDX_W-1:0] IDX = pdpc_pkg::IDX_W'(g);
         always_ff @(posedge core_clk) begin
            if (reset) begin
               store_r[g] <= is_divider(IDX) ? pdpc_pkg::RESET_DIVIDER
                                             : pdpc_pkg::RESET_OTHER;
            end else if (clk_en) begin
               if (step_apply && IDX == pdpc_pkg::PHASE_LOW_OUTPUTS) begin
                  store_r[g] <= phase_new[7:0];
               end else if (step_apply && IDX == pdpc_pkg::PHASE_HIGH_OUTPUTS) begin
                  store_r[g] <= {1'b0, phase_new[14:8]};
               end else if (rcfg_write && rcfg_idx == IDX) begin
                  store_r[g] <= reconfig_req.write_data & loc_mask(IDX);
               end
            end
         end
      end
   endgenerate

   // Read data tracks the address every enabled core cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         reconfig_read_data <= '0;
      end else if (clk_en) begin
         reconfig_read_data <= rcfg_in_range ? store_r[rcfg_idx] : '0;
      end
   end

   // Phase codes shown to the clock outputs
   always_ff @(posedge core_clk) begin
      if (reset) begin
         out_phase <= '0;
      end else if (clk_en) begin
         out_phase <= phase_flat;
      end
   end

   // ****************************************************************
   // Lock indication
   // ****************************************************************

   // Divider rewrite restarts acquisition; phase steps keep lock
   always_ff @(posedge core_clk) begin
      if (reset) begin
         lock_cnt_r <= '0;
         pll_locked <= 1'b0;
      end else if (clk_en) begin
         if (rcfg_write && rcfg_idx >= pdpc_pkg::REFERENCE_DIVIDER &&
             rcfg_idx <= pdpc_pkg::OUT4_DIVIDER) begin
            lock_cnt_r <= '0;
            pll_locked <= 1'b0;
         end else if (lock_cnt_r == pdpc_pkg::LOCK_CNT_W'(pdpc_pkg::LOCK_CYCLES - 1)) begin
            pll_locked <= 1'b1;
         end else begin
            lock_cnt_r <= lock_cnt_r + 1'b1;
         end
      end
   end

endmodule : pdpc_pll_dynamic_phase_config

// ---- pdpc_pkg.sv ----
package pdpc_pkg;

   // ****************************************************************
   // Geometry
   // ****************************************************************
   localparam int NUM_OUTPUTS  = 5;
   localparam int STORE_DEPTH  = 32;
   localparam int ADDR_W       = 6;
   localparam int IDX_W        = 5;
   localparam int DATA_W       = 8;
   localparam int PHASE_W      = 3;
   localparam int FIELD_W      = 7;

   // ****************************************************************
   // Configuration store locations
   // ****************************************************************
   localparam logic [IDX_W-1:0] REFERENCE_DIVIDER  = 5'h01;
   localparam logic [IDX_W-1:0] FEEDBACK_DIVIDER   = 5'h02;
   localparam logic [IDX_W-1:0] OUT0_DELAY         = 5'h03;
   localparam logic [IDX_W-1:0] OUT0_DIVIDER       = 5'h04;
   localparam logic [IDX_W-1:0] OUT4_DIVIDER       = 5'h0C;
   localparam logic [IDX_W-1:0] RESERVED_GAP       = 5'h0D;
   localparam logic [IDX_W-1:0] PHASE_LOW_OUTPUTS  = 5'h12;
   localparam logic [IDX_W-1:0] PHASE_HIGH_OUTPUTS = 5'h13;

   // Writable bits of each location class
   localparam logic [DATA_W-1:0] MASK_FIELD7 = 8'h7F;
   localparam logic [DATA_W-1:0] MASK_FULL   = 8'hFF;
   localparam logic [DATA_W-1:0] MASK_NONE   = 8'h00;

   // Values after reset: divide by one, no delay, phase zero
   localparam logic [DATA_W-1:0] RESET_DIVIDER = 8'h01;
   localparam logic [DATA_W-1:0] RESET_OTHER   = 8'h00;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int LOCK_TIME_NS  = 10000;
   localparam int LOCK_CYCLES   = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_CNT_W    = 11;
   localparam int STEP_HOLD_EDGES = 2;

   // ****************************************************************
   // Enumerations
   // ****************************************************************
   typedef enum logic [3:0] {
      PDPC_FB_SOURCE_SYNC = 4'h1,
      PDPC_FB_NO_COMP     = 4'h2,
      PDPC_FB_NORMAL      = 4'h4,
      PDPC_FB_ZERO_DELAY  = 4'h8
   } pdpc_fb_mode_e;

   typedef enum logic [2:0] {
      PDPC_SH_IDLE  = 3'h1,
      PDPC_SH_COUNT = 3'h2,
      PDPC_SH_DONE  = 3'h4
   } pdpc_shift_state_e;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic              select;
      logic              write_enable;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] write_data;
   } pdpc_reconfig_req_s;

   typedef struct packed {
      logic [2:0] output_select;
      logic       step_pulse;
      logic       step_up;
   } pdpc_shift_req_s;

   typedef struct packed {
      logic [1:0] reference_source;
      logic [1:0] feedback_source;
      logic [1:0] feedback_mode;
   } pdpc_static_cfg_s;

endpackage : pdpc_pkg

// ---- pdpc_pll_dynamic_phase_config_props.sv ----
module pdpc_pll_dynamic_phase_config_props (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Watched ports
   input wire logic shift_control_clock,
   input wire pdpc_pkg::pdpc_shift_req_s shift_req,
   input wire logic shift_complete,
   input wire logic reconfig_clock,
   input wire pdpc_pkg::pdpc_reconfig_req_s reconfig_req,
   input wire logic [7:0] reconfig_read_data,
   input wire logic pll_locked,
   input wire pdpc_pkg::pdpc_static_cfg_s static_cfg_held,
   input wire logic [14:0] out_phase
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // ****
   // Helper logic
   // ****
   logic rc_q_r;
   logic [10:0] lock_cnt_r;
   logic [5:0] ra;
   logic div_wr;
   // Divider write seen at a reconfig clock rise
   assign ra = reconfig_req.address;
   assign div_wr = reconfig_clock && !rc_q_r && reconfig_req.select
      && reconfig_req.write_enable && ra >= 6'h01 && ra <= 6'h0C;
   // Previous reconfig clock level
   always_ff @(posedge core_clk) begin
      rc_q_r <= reconfig_clock;
   end
   // Cycles since lock restart; saturates so it never wraps
   always_ff @(posedge core_clk) begin
      if (reset || div_wr) begin
         lock_cnt_r <= 11'h000;
      end else if (lock_cnt_r != 11'h7FF) begin
         lock_cnt_r <= lock_cnt_r + 11'h001;
      end
   end
   property p_done_fall;
      $fell(shift_complete) |-> $past(shift_control_clock) && $past(shift_req.step_pulse);
   endproperty
   a_done_fall: assert property (p_done_fall) else $error("done fell without step");
   property p_done_rise;
      $rose(shift_complete) |-> $past(shift_control_clock) && !$past(shift_control_clock, 2)
         && $past(shift_req.step_pulse);
   endproperty
   a_done_rise: assert property (p_done_rise) else $error("done rose off a rise");
   property p_phase_cause;
      !$stable(out_phase) |-> ($past(shift_complete) && !$past(shift_complete, 2))
         || $past(reconfig_req.select, 2);
   endproperty
   a_phase_cause: assert property (p_phase_cause) else $error("phase moved alone");
   property p_hole_zero;
      $past(ra) == 6'h00 || ($past(ra) >= 6'h0D && $past(ra) != 6'h12 && $past(ra) != 6'h13)
         |-> reconfig_read_data == 8'h00;
   endproperty
   a_hole_zero: assert property (p_hole_zero) else $error("hole read nonzero");
   property p_bit7_zero;
      ($past(ra) >= 6'h01 && $past(ra) <= 6'h0C) || $past(ra) == 6'h13 |-> !reconfig_read_data[7];
   endproperty
   a_bit7_zero: assert property (p_bit7_zero) else $error("bit 7 set");
   property p_lock_clear;
      div_wr |-> ##[1:2] !pll_locked;
   endproperty
   a_lock_clear: assert property (p_lock_clear) else $error("lock kept");
   property p_lock_time;
      $rose(pll_locked) |-> lock_cnt_r >= 11'h3E5 && lock_cnt_r <= 11'h3EB;
   endproperty
   a_lock_time: assert property (p_lock_time) else $error("lock time off");
   property p_cfg_frozen;
      !$past(reset) && !$past(reset, 2) |-> $stable(static_cfg_held);
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen) else $error("static cfg moved");
endmodule : pdpc_pll_dynamic_phase_config_props

bind pdpc_pll_dynamic_phase_config pdpc_pll_dynamic_phase_config_props u_props (
   .core_clk, .reset, .shift_control_clock, .shift_req, .shift_complete, .reconfig_clock,
   .reconfig_req, .reconfig_read_data, .pll_locked, .static_cfg_held, .out_phase);

// ---- pdpc_fabric_model.sv ----
module pdpc_fabric_model (
   // Core clock
   input wire logic core_clk,
   // Fabric drives
   output logic shift_control_clock,
   output pdpc_pkg::pdpc_shift_req_s shift_req,
   output logic reconfig_clock,
   output pdpc_pkg::pdpc_reconfig_req_s reconfig_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Idle state; slow clocks stand still between transfers
   // ****
   initial begin
      shift_control_clock = 1'b0;
      shift_req = '0;
      reconfig_clock = 1'b0;
      reconfig_req = '0;
   end
   // One reconfig clock rise; data inverted afterwards so stale data never matches
   task automatic write_byte(input logic [5:0] a, input logic [7:0] d, input logic s, input logic w);
      @(posedge core_clk);
      reconfig_req <= '{s, w, a, d};
      @(posedge core_clk);
      reconfig_clock <= 1'b1;
      @(posedge core_clk);
      reconfig_clock <= 1'b0;
      reconfig_req.select <= 1'b0;
      reconfig_req.write_data <= ~d;
   endtask : write_byte
   // Read address only; no clock needed
   task automatic set_addr(input logic [5:0] a);
      @(posedge core_clk);
      reconfig_req.address <= a;
   endtask : set_addr
   // Step held over n shift clock rises, then one rise with it low
   task automatic step(input logic [2:0] o, input logic up, input int n);
      @(posedge core_clk);
      shift_req <= '{o, 1'b1, up};
      repeat (n) begin
         @(posedge core_clk) shift_control_clock <= 1'b1;
         @(posedge core_clk) shift_control_clock <= 1'b0;
      end
      shift_req.step_pulse <= 1'b0;
      @(posedge core_clk) shift_control_clock <= 1'b1;
      @(posedge core_clk) shift_control_clock <= 1'b0;
      #1;
   endtask : step
endmodule : pdpc_fabric_model

// ---- pdpc_pll_dynamic_phase_config_tb_top.sv ----
module pdpc_pll_dynamic_phase_config_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Bench signals
   // ****
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   pdpc_pkg::pdpc_static_cfg_s static_cfg = 6'h2D;
   logic shift_control_clock, shift_complete, reconfig_clock, pll_locked;
   pdpc_pkg::pdpc_shift_req_s shift_req;
   pdpc_pkg::pdpc_reconfig_req_s reconfig_req;
   pdpc_pkg::pdpc_static_cfg_s static_cfg_held;
   logic [7:0] reconfig_read_data;
   logic [14:0] out_phase, exp_ph;
   int miscompares = 0;
   int checks_done = 0;
   // 100 MHz core clock
   always #5 core_clk = ~core_clk;
   pdpc_fabric_model fab (.core_clk, .shift_control_clock, .shift_req, .reconfig_clock,
      .reconfig_req);
   pdpc_pll_dynamic_phase_config dut (.core_clk, .reset, .clk_en, .static_cfg,
      .shift_control_clock, .shift_req, .shift_complete, .reconfig_clock, .reconfig_req,
      .reconfig_read_data, .pll_locked, .static_cfg_held, .out_phase);
   // Compares; case equality so unknowns fail
   task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask : check_byte
   task automatic check_flag(input string n, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         $display("unexpected %s expected %b seen %b", n, e, g);
         miscompares++;
      end
   endtask : check_flag
   task automatic check_vec(input string n, input logic [14:0] e, input logic [14:0] g);
      checks_done++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask : check_vec
   task automatic read_expect(input logic [5:0] a, input logic [7:0] e);
      fab.set_addr(a);
      repeat (2) @(posedge core_clk);
      #1;
      check_byte("read_data", e, reconfig_read_data);
   endtask : read_expect
   // Writable bits of each location
   function automatic logic [7:0] wmask(input logic [5:0] a);
      if (a == 6'h12) return 8'hFF;
      if ((a >= 6'h01 && a <= 6'h0C) || a == 6'h13) return 8'h7F;
      return 8'h00;
   endfunction : wmask
   task automatic test_reset;
      for (int a = 0; a < 34; a++) begin
         read_expect(6'(a), (a == 1 || (a > 0 && a <= 12 && a % 2 == 0)) ? 8'h01 : 8'h00);
      end
      check_flag("shift_complete", 1'b1, shift_complete);
      check_flag("pll_locked", 1'b0, pll_locked);
      $display("test reset done");
   endtask : test_reset
   task automatic test_lock;
      int i;
      // Sample a step after the edge so the launched value has settled
      for (i = 0; i < 1200 && pll_locked !== 1'b1; i++) begin
         @(posedge core_clk);
         #1;
      end
      check_flag("pll_locked", 1'b1, pll_locked);
      // A lock that never comes ends the run through the verdict
      if (pll_locked !== 1'b1) begin
         stop_test();
      end
      fab.write_byte(6'h01, 8'h03, 1'b1, 1'b1);
      repeat (2) @(posedge core_clk);
      #1;
      check_flag("pll_locked", 1'b0, pll_locked);
      read_expect(6'h01, 8'h03);
      $display("test lock done");
   endtask : test_lock
   task automatic test_write;
      logic [7:0] d;
      for (int p = 0; p < 2; p++) begin
         d = p ? 8'h80 : 8'hFF;
         for (int a = 0; a < 34; a++) begin
            fab.write_byte(6'(a), d, 1'b1, 1'b1);
            read_expect(6'(a), d & wmask(6'(a)));
         end
      end
      fab.write_byte(6'h05, 8'h2A, 1'b0, 1'b1);
      fab.write_byte(6'h05, 8'h2A, 1'b1, 1'b0);
      read_expect(6'h05, 8'h00);
      $display("test write done");
   endtask : test_write
   task automatic test_steps;
      exp_ph = 15'h0000;
      fab.write_byte(6'h12, 8'h00, 1'b1, 1'b1);
      fab.write_byte(6'h13, 8'h00, 1'b1, 1'b1);
      for (int o = 0; o < 6; o++) begin
         fab.step(3'(o), 1'b1, 2);
         if (o < 5) exp_ph[3*o +: 3] = exp_ph[3*o +: 3] + 3'h1;
         check_flag("shift_complete", 1'b1, shift_complete);
         check_vec("out_phase", exp_ph, out_phase);
      end
      fab.step(3'h2, 1'b0, 2);
      fab.step(3'h2, 1'b0, 2);
      exp_ph[8:6] = 3'h7;
      check_vec("out_phase", exp_ph, out_phase);
      fab.step(3'h4, 1'b1, 1);
      check_flag("shift_complete", 1'b0, shift_complete);
      fab.step(3'h4, 1'b1, 2);
      exp_ph[14:12] = 3'h2;
      check_vec("out_phase", exp_ph, out_phase);
      read_expect(6'h12, exp_ph[7:0]);
      read_expect(6'h13, {1'b0, exp_ph[14:8]});
      $display("test steps done");
   endtask : test_steps
   task automatic test_static;
      @(posedge core_clk);
      static_cfg <= 6'h12;
      repeat (3) @(posedge core_clk);
      #1;
      check_byte("static_cfg_held", 8'h2D, {2'b00, static_cfg_held});
      // Enable low freezes the store: a port write then is lost
      @(posedge core_clk);
      clk_en <= 1'b0;
      fab.write_byte(6'h03, 8'h55, 1'b1, 1'b1);
      @(posedge core_clk);
      clk_en <= 1'b1;
      read_expect(6'h03, 8'h00);
      $display("test static done");
   endtask : test_static
   task automatic stop_test;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      test_reset();
      test_lock();
      test_write();
      test_steps();
      test_static();
      stop_test();
   end
endmodule : pdpc_pll_dynamic_phase_config_tb_top
